// ---- led_driver.sv ----
/*
 * Registered LED pin driver with per-pin polarity.
 * Assumes enable is low until the strap has been captured.
 */
`timescale 1ns/1ns
`default_nettype none
`include "led_strap_consts.svh"
module led_driver (
   input wire logic aclk,
   input wire logic aresetn,
   led_if.drv leds
);
   logic [1:0] o_reg;
   logic [1:0] o_next;
   logic [1:0] oe_reg;
   logic [1:0] oe_next;

   // lit pin level follows the captured polarity
   always_comb begin
      o_next = leds.on ^ leds.active_low;
      oe_next = leds.enable ? `LED_ALL_LOW : 2'h0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         o_reg <= 2'h0;
         oe_reg <= 2'h0;
      end else begin
         o_reg <= o_next;
         oe_reg <= oe_next;
      end
   end

   assign leds.pin_o = o_reg;
   assign leds.pin_oe = oe_reg;
endmodule : led_driver
`default_nettype wire

// ---- led_if.sv ----
/*
 * Carrier between the pin block core and its LED pin driver.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface led_if;
   logic [1:0] on;
   logic [1:0] active_low;
   logic enable;
   logic [1:0] pin_o;
   logic [1:0] pin_oe;
   modport ctrl(output on, output active_low, output enable,
                input pin_o, input pin_oe);
   modport drv(input on, input active_low, input enable,
               output pin_o, output pin_oe);
endinterface : led_if
`default_nettype wire

// ---- led_partner.sv ----
/*
 * Far-side model: strap resistors and LED loads on the two enhanced LED
 * pins, and seven external current monitors on the sense inputs.
 * Assumes the bench chooses the strap resistors and the faults.
 */
`timescale 1ns/1ns
`default_nettype none
module led_partner (
   input wire logic [1:0] strap_level,
   input wire logic [7:1] fault,
   input wire logic [1:0] pin_o,
   input wire logic [1:0] pin_oe,
   output logic [1:0] pin,
   output logic [7:1] sense_n
);
   // device drive wins, else the strap resistor sets the level
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         pin[i] = pin_oe[i] ? pin_o[i] : strap_level[i];
      end
   end
   // monitor pulls low on fault, pull-up holds high otherwise
   assign sense_n = ~fault;
endmodule : led_partner
`default_nettype wire

// ---- led_strap_consts.svh ----
/*
 * Offsets, field positions, reset values and counts for the LED, strap
 * and over-current pin block. Assumes a 12-bit AXI4-Lite byte address.
 */
`ifndef LED_STRAP_CONSTS_SVH
`define LED_STRAP_CONSTS_SVH

// own registers, byte addresses
`define CTRL_ADDR 12'h000
`define OC_LEVEL_ADDR 12'h004
`define STRAP_ADDR 12'h008
`define INT_STATUS_ADDR 12'h00c
`define INT_MASK_ADDR 12'h010
`define LED_ON_ADDR 12'h014
// drive-level registers: printed offsets are word indices
`define UP_LEVEL_IDX 10'h0f6
`define DN_LEVEL_IDX 10'h0f8
`define UP_LEVEL_ADDR {`UP_LEVEL_IDX, 2'h0}
`define DN_LEVEL_ADDR {`DN_LEVEL_IDX, 2'h0}

// control register fields and reset value
`define CTRL_LED_EN 0
`define CTRL_STRAP_EN 1
`define CTRL_RESET 2'h2

// transmit-current level field inside the drive-level registers
`define LEVEL_MSB 1
`define LEVEL_LSB 0
`define LEVEL_RESET 8'h00

// strap defaults and timing
`define STRAP_DEFAULT 2'h0
`define LED_ALL_LOW 2'h3
`define PIN_IDLE 2'h3
`define OCS_IDLE 7'h7f
`define SETTLE_CYCLES 2'h2

// interrupt status bit of the strap capture event
`define INT_STRAP_BIT 0

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- led_strap_overcurrent_pins.sv ----
/*
 * Dual-function pins: port 1/2 enhanced LEDs that double as drive-level
 * strap, plus seven over-current sense inputs, behind AXI4-Lite.
 * Assumes pins are asynchronous, strap resistors settle before reset
 * release, and one AXI master issuing one write and one read at a time.
 */
//
// Contract
// - LED outputs driven when LED support enabled
// - strap pins sampled at reset release
// - strap selects normal or boosted drive level
// - strap loaded into both drive-level registers
// - strap bits set LED active polarity
`timescale 1ns/1ns
`default_nettype none
`include "led_strap_consts.svh"
module led_strap_overcurrent_pins (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [11:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic enhanced_led_port1_i,
   output logic enhanced_led_port1_o,
   output logic enhanced_led_port1_oe,
   input wire logic enhanced_led_port2_i,
   output logic enhanced_led_port2_o,
   output logic enhanced_led_port2_oe,
   input wire logic [7:1] overcurrent_sense_in_n,
   output logic [7:1] overcurrent_active,
   output led_strap_pkg::level_t upstream_level,
   output led_strap_pkg::level_t downstream_level,
   output logic irq
);
   import led_strap_pkg::*;
   // word match on a byte address
   function automatic logic addr_is(input logic [11:0] a,
                                    input logic [11:0] r);
      return a[11:2] == r[11:2];
   endfunction : addr_is
   function automatic logic mapped(input logic [11:0] a);
      return addr_is(a, `CTRL_ADDR) || addr_is(a, `OC_LEVEL_ADDR) ||
             addr_is(a, `STRAP_ADDR) || addr_is(a, `INT_STATUS_ADDR) ||
             addr_is(a, `INT_MASK_ADDR) || addr_is(a, `LED_ON_ADDR) ||
             addr_is(a, `UP_LEVEL_ADDR) || addr_is(a, `DN_LEVEL_ADDR);
   endfunction : mapped
   led_if leds();
   logic [1:0] led_sync;
   logic [7:1] ocs_sync;
   // pin inputs pass two flops before use
   pin_sync #(.W(2), .IDLE(`PIN_IDLE)) led_sync_u (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin({enhanced_led_port2_i, enhanced_led_port1_i}),
      .q(led_sync)
   );
   pin_sync #(.W(7), .IDLE(`OCS_IDLE)) ocs_sync_u (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(overcurrent_sense_in_n),
      .q(ocs_sync)
   );
   led_driver led_driver_u (
      .aclk(aclk),
      .aresetn(aresetn),
      .leds(leds)
   );
   // write channel state
   logic aw_have_reg, aw_have_next;
   logic [11:0] waddr_reg, waddr_next;
   logic w_have_reg, w_have_next;
   logic [31:0] wdata_reg, wdata_next;
   logic wlane_reg, wlane_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic do_write;
   // read channel state
   logic rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;
   logic [31:0] rd_word;
   // core state
   core_state_t state_reg, state_next;
   logic [1:0] settle_cnt_reg, settle_cnt_next;
   logic [1:0] strap_reg, strap_next;
   logic [7:0] up_reg, up_next;
   logic [7:0] dn_reg, dn_next;
   logic [1:0] ctrl_reg, ctrl_next;
   logic [7:0] mask_reg, mask_next;
   logic [7:0] int_status_reg, int_status_next;
   logic [1:0] led_on_reg, led_on_next;
   logic [7:1] oc_level_reg, oc_level_next;
   logic [7:1] oc_rise;
   logic sample;
   assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;
   assign sample = (state_reg == ST_SETTLE) &&
                   (settle_cnt_reg == `SETTLE_CYCLES);
   assign oc_rise = ~ocs_sync & ~oc_level_reg;
   // write address and data taken in either order, then answered
   always_comb begin
      aw_have_next = aw_have_reg;
      waddr_next = waddr_reg;
      w_have_next = w_have_reg;
      wdata_next = wdata_reg;
      wlane_next = wlane_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      if (awvalid && !aw_have_reg) begin
         aw_have_next = 1'h1;
         waddr_next = awaddr;
      end
      if (wvalid && !w_have_reg) begin
         w_have_next = 1'h1;
         wdata_next = wdata;
         wlane_next = wstrb[0];
      end
      if (bvalid_reg && bready) bvalid_next = 1'h0;
      if (do_write) begin
         aw_have_next = 1'h0;
         w_have_next = 1'h0;
         bvalid_next = 1'h1;
         bresp_next = mapped(waddr_reg) ? `RESP_OKAY : `RESP_SLVERR;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg <= 1'h0;
         waddr_reg <= 12'h000;
         w_have_reg <= 1'h0;
         wdata_reg <= 32'h0;
         wlane_reg <= 1'h0;
         bvalid_reg <= 1'h0;
         bresp_reg <= `RESP_OKAY;
      end else begin
         aw_have_reg <= aw_have_next;
         waddr_reg <= waddr_next;
         w_have_reg <= w_have_next;
         wdata_reg <= wdata_next;
         wlane_reg <= wlane_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
      end
   end
   // read decode, reserved bits read zero
   always_comb begin
      rd_word = 32'h0;
      if (addr_is(araddr, `CTRL_ADDR)) begin
         rd_word[1:0] = ctrl_reg;
      end else if (addr_is(araddr, `OC_LEVEL_ADDR)) begin
         rd_word[7:1] = oc_level_reg;
      end else if (addr_is(araddr, `STRAP_ADDR)) begin
         rd_word[2:0] = {state_reg == ST_RUN, strap_reg};
      end else if (addr_is(araddr, `INT_STATUS_ADDR)) begin
         rd_word[7:0] = int_status_reg;
      end else if (addr_is(araddr, `INT_MASK_ADDR)) begin
         rd_word[7:0] = mask_reg;
      end else if (addr_is(araddr, `LED_ON_ADDR)) begin
         rd_word[1:0] = led_on_reg;
      end else if (addr_is(araddr, `UP_LEVEL_ADDR)) begin
         rd_word[7:0] = up_reg;
      end else if (addr_is(araddr, `DN_LEVEL_ADDR)) begin
         rd_word[7:0] = dn_reg;
      end
   end
   // read answer one cycle after the address is taken
   always_comb begin
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (rvalid_reg && rready) rvalid_next = 1'h0;
      if (arvalid && !rvalid_reg) begin
         rvalid_next = 1'h1;
         rdata_next = rd_word;
         rresp_next = mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'h0;
         rdata_reg <= 32'h0;
         rresp_reg <= `RESP_OKAY;
      end else begin
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
      end
   end
   // strap capture, register writes, over-current events
   always_comb begin
      state_next = state_reg;
      settle_cnt_next = settle_cnt_reg;
      strap_next = strap_reg;
      up_next = up_reg;
      dn_next = dn_reg;
      ctrl_next = ctrl_reg;
      mask_next = mask_reg;
      led_on_next = led_on_reg;
      int_status_next = int_status_reg;
      oc_level_next = ~ocs_sync;
      unique case (state_reg)
         ST_SETTLE: begin
            settle_cnt_next = settle_cnt_reg + 2'h1;
            if (sample) begin
               state_next = ST_RUN;
               settle_cnt_next = settle_cnt_reg;
            end
         end
         ST_RUN: begin
         end
         default: begin
            state_next = ST_SETTLE;
            settle_cnt_next = 2'h0;
         end
      endcase
      if (do_write && wlane_reg) begin
         if (addr_is(waddr_reg, `CTRL_ADDR)) ctrl_next = wdata_reg[1:0];
         if (addr_is(waddr_reg, `INT_MASK_ADDR)) mask_next = wdata_reg[7:0];
         if (addr_is(waddr_reg, `LED_ON_ADDR)) led_on_next = wdata_reg[1:0];
         if (addr_is(waddr_reg, `UP_LEVEL_ADDR)) up_next = wdata_reg[7:0];
         if (addr_is(waddr_reg, `DN_LEVEL_ADDR)) dn_next = wdata_reg[7:0];
         if (addr_is(waddr_reg, `INT_STATUS_ADDR)) begin
            int_status_next = int_status_reg & ~wdata_reg[7:0];
         end
      end
      if (sample && ctrl_reg[`CTRL_STRAP_EN]) begin
         strap_next = led_sync;
         up_next[`LEVEL_MSB:`LEVEL_LSB] = led_sync;
         dn_next[`LEVEL_MSB:`LEVEL_LSB] = led_sync;
      end
      // a set in the clearing cycle wins
      int_status_next[7:1] = int_status_next[7:1] | oc_rise;
      if (sample) int_status_next[`INT_STRAP_BIT] = 1'h1;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= ST_SETTLE;
         settle_cnt_reg <= 2'h0;
         strap_reg <= `STRAP_DEFAULT;
         up_reg <= `LEVEL_RESET;
         dn_reg <= `LEVEL_RESET;
         ctrl_reg <= `CTRL_RESET;
         mask_reg <= 8'h00;
         led_on_reg <= 2'h0;
         int_status_reg <= 8'h00;
         oc_level_reg <= 7'h00;
      end else begin
         state_reg <= state_next;
         settle_cnt_reg <= settle_cnt_next;
         strap_reg <= strap_next;
         up_reg <= up_next;
         dn_reg <= dn_next;
         ctrl_reg <= ctrl_next;
         mask_reg <= mask_next;
         led_on_reg <= led_on_next;
         int_status_reg <= int_status_next;
         oc_level_reg <= oc_level_next;
      end
   end
   // LED driver: polarity from strap, else active low
   assign leds.enable = ctrl_reg[`CTRL_LED_EN] && (state_reg == ST_RUN);
   assign leds.active_low = ctrl_reg[`CTRL_STRAP_EN] ? strap_reg
                                                     : `LED_ALL_LOW;
   assign leds.on = led_on_reg;
   // outputs
   assign awready = !aw_have_reg;
   assign wready = !w_have_reg;
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;
   assign arready = !rvalid_reg;
   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;
   assign rresp = rresp_reg;
   assign enhanced_led_port1_o = leds.pin_o[0];
   assign enhanced_led_port1_oe = leds.pin_oe[0];
   assign enhanced_led_port2_o = leds.pin_o[1];
   assign enhanced_led_port2_oe = leds.pin_oe[1];
   assign overcurrent_active = oc_level_reg;
   assign upstream_level = up_reg[`LEVEL_MSB:`LEVEL_LSB];
   assign downstream_level = dn_reg[`LEVEL_MSB:`LEVEL_LSB];
   assign irq = |(int_status_reg & mask_reg);
   // checks
   led_drive_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ctrl_reg[`CTRL_LED_EN] && state_reg == ST_RUN
      |=> enhanced_led_port1_oe && enhanced_led_port2_oe)
      else $error("led pins not driven while enabled");

   strap_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> ##3 (state_reg == ST_RUN) && !$past(sample, 2))
      else $error("strap not sampled three cycles after release");

   strap_capture_a: assert property (@(posedge aclk) disable iff (!aresetn)
      sample && ctrl_reg[`CTRL_STRAP_EN] |=> strap_reg == $past(led_sync))
      else $error("strap value not captured");

   level_both_a: assert property (@(posedge aclk) disable iff (!aresetn)
      sample && ctrl_reg[`CTRL_STRAP_EN]
      |=> upstream_level == strap_reg && downstream_level == strap_reg)
      else $error("drive level does not follow strap");

   field_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
      sample && ctrl_reg[`CTRL_STRAP_EN]
      |=> up_reg[1:0] == $past(led_sync) && dn_reg[1:0] == $past(led_sync))
      else $error("level field not loaded from strap");

   led_polarity_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state_reg == ST_RUN && ctrl_reg[`CTRL_STRAP_EN]
      |=> enhanced_led_port1_o == ($past(led_on_reg[0]) ^ $past(strap_reg[0]))
       && enhanced_led_port2_o == ($past(led_on_reg[1]) ^ $past(strap_reg[1])))
      else $error("led polarity differs from strap");

   oc_sense_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && $past(aresetn, 2) && $past(aresetn, 3)
      |-> overcurrent_active == ~$past(overcurrent_sense_in_n, 3))
      else $error("over-current level not three cycles from pin");

   oc_event_a: assert property (@(posedge aclk) disable iff (!aresetn)
      oc_rise != 7'h00 |=> (int_status_reg[7:1] & $past(oc_rise)) == $past(oc_rise))
      else $error("over-current event not latched");
   strap_seen_c: cover property (@(posedge aclk) disable iff (!aresetn)
      sample && led_sync == 2'h3);
   oc_irq_c: cover property (@(posedge aclk) disable iff (!aresetn)
      oc_rise != 7'h00 ##[1:20] irq);
   clear_race_c: cover property (@(posedge aclk) disable iff (!aresetn)
      do_write && addr_is(waddr_reg, `INT_STATUS_ADDR) && oc_rise != 7'h00);
endmodule : led_strap_overcurrent_pins
`default_nettype wire

// ---- led_strap_pkg.sv ----
/*
 * Types shared by the LED, strap and over-current pin block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package led_strap_pkg;
   typedef logic [1:0] level_t;
   typedef enum logic [1:0] {
      ST_SETTLE = 2'h1,
      ST_RUN = 2'h2
   } core_state_t;
endpackage : led_strap_pkg
`default_nettype wire

// ---- pin_sync.sv ----
/*
 * Two-flop synchroniser for pin inputs.
 * Assumes the pins are asynchronous to aclk; reset loads the idle level.
 */
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] IDLE = '1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] pin,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;

   // first stage feeds only the second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_reg <= IDLE;
         s2_reg <= IDLE;
      end else begin
         s1_reg <= pin;
         s2_reg <= s1_reg;
      end
   end

   assign q = s2_reg;
endmodule : pin_sync
`default_nettype wire

// ---- tb_led_strap_overcurrent_pins.sv ----
/*
 * Self-checking bench for the LED, strap and over-current pin block.
 * Assumes the design and led_partner are compiled before this file.
 */
`timescale 1ns/1ns
`default_nettype none
`include "led_strap_consts.svh"
module tb_led_strap_overcurrent_pins;
   import led_strap_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp, pin, pin_o, pin_oe;
   logic [31:0] rdata;
   logic [1:0] strap = 2'h0;
   logic [7:1] fault = 7'h00, sense_n, overcurrent_active;
   level_t upstream_level, downstream_level;
   int n_errors = 0;
   int compares = 0;

   always #4 aclk = ~aclk;

   led_strap_overcurrent_pins i_led_strap_overcurrent_pins (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .enhanced_led_port1_i(pin[0]), .enhanced_led_port1_o(pin_o[0]),
      .enhanced_led_port1_oe(pin_oe[0]), .enhanced_led_port2_i(pin[1]),
      .enhanced_led_port2_o(pin_o[1]), .enhanced_led_port2_oe(pin_oe[1]),
      .overcurrent_sense_in_n(sense_n),
      .overcurrent_active(overcurrent_active),
      .upstream_level(upstream_level), .downstream_level(downstream_level),
      .irq(irq));

   led_partner i_led_partner (.strap_level(strap), .fault(fault),
      .pin_o(pin_o), .pin_oe(pin_oe), .pin(pin), .sense_n(sense_n));

   // verdict and end of run
   task automatic final_report();
      $display("checks %0d, mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : final_report

   task automatic timed_out(input string what);
      $display("CHECK FAILED %s expected answer seen none", what);
      n_errors++;
      final_report();
   endtask : timed_out

   task automatic check_word(input string what, input logic [31:0] exp,
                             input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         n_errors++;
      end
   endtask : check_word

   // reset held two cycles, then the synchroniser and strap edges
   task automatic do_reset();
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
   endtask : do_reset

   // one write: address and data offered together, then the response
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                            input logic [3:0] s, output logic [1:0] r);
      int n;
      bit aw_ok, w_ok, b_ok;
      aw_ok = 0;
      w_ok = 0;
      b_ok = 0;
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50 && !b_ok; n++) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            aw_ok = 1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w_ok = 1;
            wvalid <= 1'b0;
         end
         if (bvalid === 1'b1) begin
            b_ok = 1;
            r = bresp;
            bready <= 1'b0;
         end
      end
      // one edge with bready low before the next request
      @(posedge aclk);
      if (!b_ok) timed_out("write response");
   endtask : axi_write

   task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
                           output logic [1:0] r);
      int n;
      bit r_ok;
      r_ok = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50 && !r_ok; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            r_ok = 1;
            d = rdata;
            r = rresp;
            rready <= 1'b0;
         end
      end
      // one edge with rready low before the next request
      @(posedge aclk);
      if (!r_ok) timed_out("read data");
   endtask : axi_read

   // read one register and compare its word
   task automatic read_check(input string what, input logic [11:0] a,
                             input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      axi_read(a, d, r);
      check_word(what, exp, d);
   endtask : read_check

   // strap captured at release, loaded into levels, sets LED polarity
   task automatic test_strap(input logic [1:0] s);
      logic [1:0] r;
      int n;
      strap <= s;
      do_reset();
      check_word("upstream_level", {30'h0, s}, {30'h0, upstream_level});
      check_word("downstream_level", {30'h0, s}, {30'h0, downstream_level});
      read_check("up level reg", `UP_LEVEL_ADDR, {30'h0, s});
      read_check("dn level reg", `DN_LEVEL_ADDR, {30'h0, s});
      read_check("strap reg", `STRAP_ADDR, {29'h0, 1'b1, s});
      read_check("ctrl reg", `CTRL_ADDR, 32'h2);
      read_check("int status", `INT_STATUS_ADDR, 32'h1);
      check_word("irq masked", 32'h0, {31'h0, irq});
      check_word("led oe off", 32'h0, {30'h0, pin_oe});
      axi_write(`LED_ON_ADDR, 32'h1, 4'h1, r);
      axi_write(`CTRL_ADDR, 32'h3, 4'h1, r);
      for (n = 0; n < 20 && pin_oe !== 2'h3; n++) @(posedge aclk);
      if (pin_oe !== 2'h3) timed_out("led oe");
      check_word("led oe", 32'h3, {30'h0, pin_oe});
      check_word("led pins", {30'h0, 2'h1 ^ s}, {30'h0, pin});
      $display("test_strap %0d done", s);
   endtask : test_strap

   // sense inputs, sticky status, mask and clear
   task automatic test_overcurrent();
      logic [1:0] r;
      int n;
      axi_write(`INT_STATUS_ADDR, 32'hff, 4'h1, r);
      axi_write(`INT_MASK_ADDR, 32'hfe, 4'h1, r);
      check_word("irq idle", 32'h0, {31'h0, irq});
      fault <= 7'h41;
      for (n = 0; n < 10 && overcurrent_active !== 7'h41; n++) @(posedge aclk);
      if (overcurrent_active !== 7'h41) timed_out("oc active");
      check_word("oc active", 32'h41, {25'h0, overcurrent_active});
      read_check("oc level", `OC_LEVEL_ADDR, 32'h82);
      read_check("int status oc", `INT_STATUS_ADDR, 32'h82);
      check_word("irq oc", 32'h1, {31'h0, irq});
      axi_write(`INT_MASK_ADDR, 32'h00, 4'h1, r);
      check_word("irq masked", 32'h0, {31'h0, irq});
      axi_write(`INT_MASK_ADDR, 32'h82, 4'h1, r);
      axi_write(`INT_STATUS_ADDR, 32'h02, 4'h1, r);
      check_word("irq port7", 32'h1, {31'h0, irq});
      axi_write(`INT_STATUS_ADDR, 32'h80, 4'h1, r);
      check_word("irq cleared", 32'h0, {31'h0, irq});
      fault <= 7'h00;
      for (n = 0; n < 10 && overcurrent_active !== 7'h00; n++) @(posedge aclk);
      if (overcurrent_active !== 7'h00) timed_out("oc idle");
      check_word("oc idle", 32'h0, {25'h0, overcurrent_active});
      $display("test_overcurrent done");
   endtask : test_overcurrent

   // level registers writable, unmapped and strobe-less writes refused
   task automatic test_bus();
      logic [31:0] d;
      logic [1:0] r;
      axi_read(12'h100, d, r);
      check_word("unmapped rresp", {30'h0, `RESP_SLVERR}, {30'h0, r});
      check_word("unmapped rdata", 32'h0, d);
      axi_write(12'h100, 32'hff, 4'h1, r);
      check_word("unmapped bresp", {30'h0, `RESP_SLVERR}, {30'h0, r});
      axi_write(`UP_LEVEL_ADDR, 32'ha5, 4'h1, r);
      check_word("up bresp", {30'h0, `RESP_OKAY}, {30'h0, r});
      read_check("up level rw", `UP_LEVEL_ADDR, 32'ha5);
      check_word("upstream_level rw", 32'h1, {30'h0, upstream_level});
      axi_write(`DN_LEVEL_ADDR, 32'h5a, 4'h0, r);
      read_check("dn no strobe", `DN_LEVEL_ADDR, 32'h3); // strap 3 kept
      axi_write(`DN_LEVEL_ADDR, 32'h5a, 4'h1, r);
      check_word("downstream_level rw", 32'h2, {30'h0, downstream_level});
      $display("test_bus done");
   endtask : test_bus

   // strap disabled before the capture edge: levels stay, LEDs active low
   task automatic test_strap_off();
      logic [1:0] r;
      strap <= 2'h1;
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      axi_write(`CTRL_ADDR, 32'h1, 4'h1, r);
      axi_write(`LED_ON_ADDR, 32'h3, 4'h1, r);
      repeat (2) @(posedge aclk);
      check_word("up level off", 32'h0, {30'h0, upstream_level});
      read_check("dn reg off", `DN_LEVEL_ADDR, 32'h0);
      read_check("strap off", `STRAP_ADDR, 32'h4);
      check_word("led oe on", 32'h3, {30'h0, pin_oe});
      check_word("led pins low", 32'h0, {30'h0, pin});
      $display("test_strap_off done");
   endtask : test_strap_off

   // main sequence
   initial begin
      for (int s = 0; s < 4; s++) begin
         test_strap(s[1:0]);
      end
      test_overcurrent();
      test_bus();
      test_strap_off();
      final_report();
   end
endmodule : tb_led_strap_overcurrent_pins
`default_nettype wire
